//--- design/aic_top.sv
// Purpose: Converter input, clock and reference configuration registers.
// Assumes: Plain strobe register port; read data valid the cycle after.
// Notes: Drives analog switch enables and the conversion clock enable.
`timescale 1ns/1ps
`include "aic_defs.svh"
module aic_top (
	input  wire logic                   i_clk,            // System clock, 50 MHz.
	input  wire logic                   i_arst_n,         // Asynchronous reset, active low.
	input  wire logic [`AIC_ADDR_W-1:0] i_addr,           // Register address.
	input  wire logic [7:0]             i_wdata,          // Write data.
	input  wire logic                   i_wr,             // Write strobe.
	input  wire logic                   i_rd,             // Read strobe.
	input  wire logic [3:0]             i_ext_chan_sel,   // External channel select.
	output logic [7:0]                  o_rdata,          // Read data, one cycle later.
	output logic                        o_conv_clk_en,    // Conversion clock enable.
	output logic [11:0]                 o_ext_chan_on,    // Per-pin channel switch.
	output logic                        o_sel_supply,     // Supply onto converter input.
	output logic                        o_sel_amp,        // Amplified ref onto input.
	output logic                        o_sel_gnd,        // Converter input grounded.
	output logic [1:0]                  o_in_scale,       // 0:/1, 1:/2, 2:/4.
	output logic                        o_ref_supply,     // Reference from supply.
	output logic                        o_ref_pin_on,     // External reference pin switch.
	output logic                        o_ref_amp,        // Reference from amplifier.
	output logic                        o_gain_amp_enable,// Amplifier bias on.
	output logic                        o_amp_ref_pin_on, // Reference pin into amplifier.
	output logic                        o_amp_bandgap_on, // Bandgap into amplifier.
	output logic [1:0]                  o_gain_select,    // Amplifier gain code.
	output logic                        o_bandgap_enable  // Bandgap circuit on.
);
	logic [7:0]              inclk_q;   // Input and clock configuration.
	logic [7:0]              refgain_q; // Reference and gain configuration.
	logic [7:0]              bandgap_q; // Bandgap control.
	logic [7:0]              rdata_d;   // Read mux.
	aic_pkg::aic_in_path_t   in_path;   // Decoded input path.
	aic_pkg::aic_ref_path_t  ref_path;  // Decoded reference path.
	logic                    ext_sel;   // External input chosen.

	// Masking on write keeps unimplemented bits at zero for reads.
	function automatic logic [7:0] aic_wr_val(input logic [7:0] d, input logic [7:0] m);
		aic_wr_val = d & m;
	endfunction : aic_wr_val

	// Input and clock register.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			inclk_q <= `AIC_RESET_BYTE;
		end else if (i_wr && i_addr == `AIC_OFF_INCLK) begin
			inclk_q <= aic_wr_val(i_wdata, `AIC_INCLK_MASK);
		end
	end

	// Reference and gain register.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			refgain_q <= `AIC_RESET_BYTE;
		end else if (i_wr && i_addr == `AIC_OFF_REFGAIN) begin
			refgain_q <= aic_wr_val(i_wdata, `AIC_REFGAIN_MASK);
		end
	end

	// Bandgap register; off after reset.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bandgap_q <= `AIC_RESET_BYTE;
		end else if (i_wr && i_addr == `AIC_OFF_BANDGAP) begin
			bandgap_q <= aic_wr_val(i_wdata, `AIC_BANDGAP_MASK);
		end
	end

	// Read mux; the unmapped offset reads zero.
	always_comb begin
		case (i_addr)
			`AIC_OFF_INCLK:   rdata_d = inclk_q;
			`AIC_OFF_REFGAIN: rdata_d = refgain_q;
			`AIC_OFF_BANDGAP: rdata_d = bandgap_q;
			default:          rdata_d = `AIC_RESET_BYTE;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= `AIC_RESET_BYTE;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= `AIC_RESET_BYTE;
		end
	end

	// Conversion clock divider.
	aic_clk_div u_div (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_sel    (inclk_q[`AIC_CKS_MSB:`AIC_CKS_LSB]),
		.o_en     (o_conv_clk_en)
	);

	// Path decode.
	aic_path_dec u_dec (
		.i_src      (inclk_q[`AIC_SRC_MSB:`AIC_SRC_LSB]),
		.i_ref      (refgain_q[`AIC_REF_MSB:`AIC_REF_LSB]),
		.o_in_path  (in_path),
		.o_scale    (o_in_scale),
		.o_ref_path (ref_path)
	);

	assign ext_sel      = (in_path == aic_pkg::AIC_IN_EXT);
	assign o_sel_supply = (in_path == aic_pkg::AIC_IN_SUPPLY);
	assign o_sel_amp    = (in_path == aic_pkg::AIC_IN_AMP);
	assign o_sel_gnd    = (in_path == aic_pkg::AIC_IN_GND);

	// One switch per pin; codes 12 to 15 leave every pin open (floating input).
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_chan
			assign o_ext_chan_on[g] = ext_sel && (i_ext_chan_sel == 4'(g));
		end
	endgenerate

	// Reference switches; internal choices open the external pin.
	assign o_ref_supply = (ref_path == aic_pkg::AIC_REF_SUPPLY);
	assign o_ref_amp    = (ref_path == aic_pkg::AIC_REF_AMP);
	assign o_ref_pin_on = (ref_path == aic_pkg::AIC_REF_PIN);

	// Amplifier controls straight from stored bits.
	assign o_gain_amp_enable = refgain_q[`AIC_AMPEN_BIT];
	assign o_amp_bandgap_on  = refgain_q[`AIC_AMPIS_BIT];
	assign o_amp_ref_pin_on  = !refgain_q[`AIC_AMPIS_BIT];
	assign o_gain_select     = refgain_q[`AIC_GAIN_MSB:`AIC_GAIN_LSB];
	assign o_bandgap_enable  = bandgap_q[`AIC_BGEN_BIT];

	a_int_no_pins: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:4] inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h7}) |-> o_ext_chan_on == 12'h000)
		else $error("External pin connected while internal source selected.");
	a_ext_src_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:4] inside {4'h0, 4'h4, 4'hC, 4'hF} && i_ext_chan_sel < 4'hC)
		|-> $onehot(o_ext_chan_on))
		else $error("External source did not connect exactly one pin.");
	a_ext_code_four: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:4] == 4'h4 && i_ext_chan_sel == 4'h3) |-> o_ext_chan_on == 12'h008)
		else $error("Code four did not pick the selected pin.");
	a_supply_half: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:4] == 4'h2) |-> (o_sel_supply && o_in_scale == 2'h1))
		else $error("Half supply not routed.");
	a_amp_quarter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:4] == 4'h7) |-> (o_sel_amp && o_in_scale == 2'h2))
		else $error("Quarter amplified reference not routed.");
	a_gnd_input: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(inclk_q[7:6] == 2'h2) |-> (o_sel_gnd && !o_sel_amp && !o_sel_supply))
		else $error("Ground code did not ground the input.");
	a_read_zeros: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_rd && i_addr == `AIC_OFF_BANDGAP) |=> o_rdata[7:1] == 7'h00)
		else $error("Unimplemented bandgap bits read nonzero.");
	a_write_back: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_wr && i_addr == `AIC_OFF_REFGAIN) |=> o_gain_select == $past(i_wdata[1:0]))
		else $error("Gain field not taken from write.");
	a_ref_pin_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		refgain_q[3] |-> (!o_ref_pin_on && o_ref_amp))
		else $error("Reference pin left on with internal reference.");
	a_bg_input: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_amp_bandgap_on |-> !o_amp_ref_pin_on)
		else $error("Reference pin into amplifier while bandgap chosen.");
	a_bg_enable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_wr && i_addr == `AIC_OFF_BANDGAP) |=> o_bandgap_enable == $past(i_wdata[0]))
		else $error("Bandgap enable not taken from write.");
endmodule : aic_top

//--- design/aic_defs.svh
// Purpose: Constants for the converter input and reference configuration block.
// Assumes: Byte-wide registers on a plain strobe port, one clock.
// Notes: Register offsets are local choices; fields follow the byte layouts.
`ifndef AIC_DEFS_SVH
`define AIC_DEFS_SVH
`define AIC_ADDR_W        2
`define AIC_OFF_INCLK     2'h0
`define AIC_OFF_REFGAIN   2'h1
`define AIC_OFF_BANDGAP   2'h2
`define AIC_RESET_BYTE    8'h00
`define AIC_INCLK_MASK    8'hF7
`define AIC_REFGAIN_MASK  8'h9F
`define AIC_BANDGAP_MASK  8'h01
`define AIC_SRC_MSB       7
`define AIC_SRC_LSB       4
`define AIC_CKS_MSB       2
`define AIC_CKS_LSB       0
`define AIC_AMPEN_BIT     7
`define AIC_AMPIS_BIT     4
`define AIC_REF_MSB       3
`define AIC_REF_LSB       2
`define AIC_GAIN_MSB      1
`define AIC_GAIN_LSB      0
`define AIC_BGEN_BIT      0
`define AIC_DIV_W         7
`endif

//--- design/aic_pkg.sv
// Purpose: Types for the converter input and reference configuration block.
// Assumes: Used by qualified names only.
// Notes: Encodings are one-hot path enables, not the hardware's select codes.
package aic_pkg;
	// Converter input path choices, one-hot for the analog switch drivers.
	typedef enum logic [4:0] {
		AIC_IN_EXT    = 5'h01,
		AIC_IN_SUPPLY = 5'h02,
		AIC_IN_AMP    = 5'h04,
		AIC_IN_GND    = 5'h08,
		AIC_IN_SPARE  = 5'h10
	} aic_in_path_t;
	// Reference path choices.
	typedef enum logic [2:0] {
		AIC_REF_SUPPLY = 3'h1,
		AIC_REF_PIN    = 3'h2,
		AIC_REF_AMP    = 3'h4
	} aic_ref_path_t;
endpackage : aic_pkg

//--- design/aic_clk_div.sv
// Purpose: Conversion clock enable from the system clock.
// Assumes: Divider code may change at any time.
// Notes: Emits a one-cycle enable every 2^code cycles.
`timescale 1ns/1ps
`include "aic_defs.svh"
module aic_clk_div (
	input  wire logic       i_clk,    // System clock.
	input  wire logic       i_arst_n, // Asynchronous reset, active low.
	input  wire logic [2:0] i_sel,    // Divider exponent.
	output logic            o_en      // One-cycle conversion clock enable.
);
	logic [`AIC_DIV_W-1:0] cnt_q;   // Free-running count.
	logic [`AIC_DIV_W-1:0] mask_w;  // Low bits that must be all ones.

	// A mask rather than a compare means a code change never strands the counter.
	assign mask_w = `AIC_DIV_W'((8'h01 << i_sel) - 8'h01);

	// Count every cycle; wraps freely.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + `AIC_DIV_W'(1);
		end
	end

	// Code 0 gives an enable every cycle, code 7 every 128.
	assign o_en = ((cnt_q & mask_w) == mask_w);

	// The code must hold across both cycles; a change to code 0 legally fires again at once.
	a_div_period: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(o_en && i_sel == 3'h1) ##1 (i_sel == 3'h1) |-> !o_en)
		else $error("Divide-by-two enable fired twice in a row.");
endmodule : aic_clk_div

//--- design/aic_path_dec.sv
// Purpose: Decode input source and reference selections into switch enables.
// Assumes: Pure combinational decode of stored fields.
// Notes: Used by the top; no state.
`timescale 1ns/1ps
module aic_path_dec (
	input  wire logic [3:0]            i_src,     // Input source select.
	input  wire logic [1:0]            i_ref,     // Reference source select.
	output aic_pkg::aic_in_path_t      o_in_path, // Chosen input path.
	output logic [1:0]                 o_scale,   // 0:/1, 1:/2, 2:/4.
	output aic_pkg::aic_ref_path_t     o_ref_path // Chosen reference path.
);
	// Input source decode; reserved 0011 drives a quarter supply, unlisted codes ground the input.
	always_comb begin
		o_in_path = aic_pkg::AIC_IN_GND;
		o_scale   = 2'h0;
		case (i_src)
			4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: begin
				o_in_path = aic_pkg::AIC_IN_EXT;
			end
			4'h1: begin
				o_in_path = aic_pkg::AIC_IN_SUPPLY;
			end
			4'h2: begin
				o_in_path = aic_pkg::AIC_IN_SUPPLY;
				o_scale   = 2'h1;
			end
			4'h3: begin
				// Reserved code drives a quarter supply, as the divider tap exists.
				o_in_path = aic_pkg::AIC_IN_SUPPLY;
				o_scale   = 2'h2;
			end
			4'h5, 4'h6, 4'h7: begin
				o_in_path = aic_pkg::AIC_IN_AMP;
				o_scale   = i_src[1:0] - 2'h1;
			end
			default: begin
				o_in_path = aic_pkg::AIC_IN_GND;
			end
		endcase
	end

	// Reference decode.
	always_comb begin
		case (i_ref)
			2'h0:    o_ref_path = aic_pkg::AIC_REF_SUPPLY;
			2'h1:    o_ref_path = aic_pkg::AIC_REF_PIN;
			default: o_ref_path = aic_pkg::AIC_REF_AMP;
		endcase
	end
endmodule : aic_path_dec

//--- testbench/adc_input_reference_config_test.sv
// Purpose: Self-checking bench for the converter input and reference configuration block.
// Assumes: Offsets 0, 1 and 2 hold the registers; offset 3 is unmapped and reads zero.
// Notes: A register model predicts every read and every switch output after each write.
`timescale 1ns/1ps
module adc_input_reference_config_test;
	logic        i_clk;          // System clock, 50 MHz.
	logic        i_arst_n;       // Asynchronous reset, active low.
	logic [1:0]  i_addr;         // Register address.
	logic [7:0]  i_wdata;        // Write data.
	logic        i_wr;           // Write strobe.
	logic        i_rd;           // Read strobe.
	logic [3:0]  i_ext_chan_sel; // External channel field.
	logic [7:0]  o_rdata;        // Read data.
	logic        o_conv_clk_en;  // Conversion clock enable.
	logic [11:0] o_ext_chan_on;  // Per-pin switches.
	logic        o_sel_supply, o_sel_amp, o_sel_gnd, o_ref_supply, o_ref_pin_on, o_ref_amp;
	logic        o_gain_amp_enable, o_amp_ref_pin_on, o_amp_bandgap_on, o_bandgap_enable;
	logic [1:0]  o_in_scale, o_gain_select;
	int          fails;          // Mismatches counted.
	int          check_count;    // Comparisons counted.
	logic [7:0]  mreg [0:3];     // Model registers; entry 3 never changes from zero.
	logic [11:0] cnt;            // Pulse count; four-state so an unknown enable shows.

	// Free-running system clock.
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	aic_top DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_ext_chan_sel(i_ext_chan_sel), .o_rdata(o_rdata),
		.o_conv_clk_en(o_conv_clk_en), .o_ext_chan_on(o_ext_chan_on),
		.o_sel_supply(o_sel_supply), .o_sel_amp(o_sel_amp), .o_sel_gnd(o_sel_gnd),
		.o_in_scale(o_in_scale), .o_ref_supply(o_ref_supply), .o_ref_pin_on(o_ref_pin_on),
		.o_ref_amp(o_ref_amp), .o_gain_amp_enable(o_gain_amp_enable),
		.o_amp_ref_pin_on(o_amp_ref_pin_on), .o_amp_bandgap_on(o_amp_bandgap_on),
		.o_gain_select(o_gain_select), .o_bandgap_enable(o_bandgap_enable));

	// Compares one value; case inequality so an unknown never passes.
	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then stops the run.
	task automatic results();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	// Predicts the configuration outputs except the conversion clock enable from the model registers; input scale only for internal sources.
	task automatic check_outputs();
		logic [3:0] s;
		logic [7:0] g;
		logic       ext;
		logic       inner;
		s = mreg[0][7:4];
		g = mreg[1];
		ext = (s == 4'h0) || (s == 4'h4) || (s[3:2] == 2'b11);
		inner = (s[3] == 1'b0) && (s[1:0] != 2'b00);
		check("ext_chan_on", o_ext_chan_on, (ext && i_ext_chan_sel < 4'hC) ? 12'h001 << i_ext_chan_sel : 12'h000);
		check("input_path", 12'({o_sel_supply, o_sel_amp, o_sel_gnd}), 12'({inner && !s[2], inner && s[2], s[3:2] == 2'b10}));
		if (inner) begin
			check("in_scale", 12'(o_in_scale), 12'(s[1:0] - 2'h1));
		end
		check("ref_path", 12'({o_ref_supply, o_ref_pin_on, o_ref_amp}), 12'({g[3:2] == 2'b00, g[3:2] == 2'b01, g[3]}));
		check("amp_ctrl", 12'({o_gain_amp_enable, o_amp_ref_pin_on, o_amp_bandgap_on, o_gain_select}), 12'({g[7], !g[4], g[4], g[1:0]}));
		check("bandgap_enable", 12'(o_bandgap_enable), 12'(mreg[2][0]));
	endtask : check_outputs

	// One-cycle write; the model drops unimplemented bits and ignores offset 3.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		case (a)
			2'h0: mreg[0] = d & 8'hF7;
			2'h1: mreg[1] = d & 8'h9F;
			2'h2: mreg[2] = d & 8'h01;
			default: mreg[3] = 8'h00;
		endcase
		#1;
		check_outputs();
	endtask : wr

	// One-cycle read; data stand only in the following cycle.
	task automatic rd_check(input logic [1:0] a);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		check("rdata", 12'(o_rdata), 12'(mreg[a]));
		@(posedge i_clk);
		#1;
		check("rdata_idle", 12'(o_rdata), 12'h000);
	endtask : rd_check

	// Holds reset for four cycles and clears the model.
	task automatic do_reset();
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		for (int a = 0; a < 4; a++) mreg[a] = 8'h00;
		#1;
		check_outputs();
	endtask : do_reset

	// Cuts a hang short; a run that reaches it counts as a mismatch.
	initial begin
		#2000000;
		fails++;
		results();
	end

	initial begin
		{i_addr, i_wdata, i_wr, i_rd, i_ext_chan_sel} = '0;
		i_arst_n = 1'b0;
		fails = 0;
		check_count = 0;
		for (int a = 0; a < 4; a++) mreg[a] = 8'h00;
		void'($urandom(32'h2c3efe87));
		do_reset();
		for (int a = 0; a < 4; a++) rd_check(a[1:0]);
		// Every source code, each paired with one reference and gain setting and a random input choice.
		for (int s = 0; s < 16; s++) begin
			@(posedge i_clk);
			i_ext_chan_sel <= 4'($urandom_range(15, 0));
			wr(2'h0, {s[3:0], 4'($urandom_range(15, 0))});
			wr(2'h1, 8'(s * 17));
			wr(2'h2, 8'($urandom_range(255, 0)));
			for (int a = 0; a < 3; a++) rd_check(a[1:0]);
		end
		// Random traffic, unmapped offset included, reads mixed in.
		repeat (40) begin
			@(posedge i_clk);
			i_ext_chan_sel <= 4'($urandom_range(15, 0));
			wr(2'($urandom_range(3, 0)), 8'($urandom_range(255, 0)));
			rd_check(2'($urandom_range(3, 0)));
		end
		// Software order: bandgap on, let it settle, then amplifier fed from the bandgap.
		@(posedge i_clk);
		i_ext_chan_sel <= 4'h3;
		wr(2'h2, 8'h01);
		repeat (50) @(posedge i_clk);
		wr(2'h1, 8'h98);
		wr(2'h0, 8'h40);
		rd_check(2'h1);
		// Conversion clock rate for each divider code, counted once settled.
		for (int k = 0; k < 8; k++) begin
			wr(2'h0, {5'h00, k[2:0]});
			repeat (200) @(posedge i_clk);
			cnt = 12'h000;
			repeat (256) begin
				@(posedge i_clk);
				#1;
				cnt = cnt + 12'(o_conv_clk_en);
			end
			check("conv_clk_pulses", cnt, 12'(256 >> k));
		end
		// A second reset in mid-run returns every register to zero.
		wr(2'h1, 8'hFF);
		wr(2'h2, 8'hFF);
		do_reset();
		for (int a = 0; a < 3; a++) rd_check(a[1:0]);
		results();
	end
endmodule : adc_input_reference_config_test
